//--- logic/bax_alu.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Subtract: file minus working, two's complement
// [RULE_02] Carry/digit-carry set when no borrow
// [RULE_03] XOR working with addressed file register
// [RULE_04] Destination bit: 0 working, 1 file
// [RULE_05] XOR literal into working, zero only
// [RULE_06] Swap nibbles, flags unchanged
// [RULE_07] Each instruction completes in one cycle
// [RULE_08] Zero flag set when result is zero
module bax_alu
  import bax_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              enable_i,
  input  wire logic              instr_valid_i,
  input  wire bax_instr_t        instr_i,
  input  wire logic [DATA_W-1:0] file_rd_data_i,
  output logic                   file_wr_en_o,
  output logic      [ADDR_W-1:0] file_wr_addr_o,
  output logic      [DATA_W-1:0] file_wr_data_o,
  output logic      [DATA_W-1:0] w_o,
  output bax_flags_t             flags_o,
  output logic                   done_o
);
  function automatic logic [NIB_W:0] nib_sub(input logic [NIB_W-1:0] a,
                                             input logic [NIB_W-1:0] b);
    nib_sub = {1'b0, a} - {1'b0, b};
  endfunction

  logic [DATA_W-1:0] w;
  logic [DATA_W-1:0] next_w;
  bax_flags_t        flags;
  bax_flags_t        next_flags;
  logic              wr_en;
  logic              next_wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] next_wr_data;
  logic              done;
  logic              next_done;
  logic [DATA_W:0]   diff;
  logic [NIB_W:0]    ndiff;
  logic [DATA_W-1:0] result;

  always_comb begin
    next_w       = w;
    next_flags   = flags;
    next_wr_en   = 1'b0;
    next_wr_addr = instr_i.addr;
    next_wr_data = wr_data;
    next_done    = 1'b0;
    diff   = {1'b0, file_rd_data_i} - {1'b0, w};                  // [RULE_01]
    ndiff  = nib_sub(file_rd_data_i[NIB_W-1:0], w[NIB_W-1:0]);
    result = '0;
    if (instr_valid_i) begin
      next_done = 1'b1;                                            // [RULE_07]
      unique case (instr_i.op)
        sub_w_from_file_op: begin
          result = diff[DATA_W-1:0];                               // [RULE_01]
          next_flags.carry            = ~diff[DATA_W];             // [RULE_02]
          next_flags.digit_carry_flag = ~ndiff[NIB_W];             // [RULE_02]
          next_flags.zero             = (result == '0);            // [RULE_08]
        end
        xor_w_file_op: begin
          result = w ^ file_rd_data_i;                             // [RULE_03]
          next_flags.zero = (result == '0);                        // [RULE_08]
        end
        xor_literal_op: begin
          result = w ^ instr_i.literal;                            // [RULE_05]
          next_flags.zero = (result == '0);                        // [RULE_08]
        end
        nibble_swap_op: begin
          result = {file_rd_data_i[NIB_W-1:0],
                    file_rd_data_i[DATA_W-1:NIB_W]};               // [RULE_06]
        end
      endcase
      if (instr_i.op == xor_literal_op || instr_i.dest == DEST_W) begin
        next_w = result;                                           // [RULE_04] [RULE_05]
      end else begin
        next_wr_en   = 1'b1;                                       // [RULE_04]
        next_wr_data = result;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      w       <= W_RESET;
      flags   <= '{FLAG_RESET, FLAG_RESET, FLAG_RESET};
      wr_en   <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      done    <= 1'b0;
    end else if (enable_i) begin
      w       <= next_w;
      flags   <= next_flags;
      wr_en   <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      done    <= next_done;
    end
  end

  assign w_o            = w;
  assign flags_o        = flags;
  assign file_wr_en_o   = wr_en;
  assign file_wr_addr_o = wr_addr;
  assign file_wr_data_o = wr_data;
  assign done_o         = done;
endmodule

//--- logic/bax_file_mem.sv
`timescale 1ns/1ps
module bax_file_mem
  import bax_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FILE_DEPTH,
  parameter int unsigned AW    = ADDR_W
) (
  input  wire logic             clock_i,
  input  wire logic             enable_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i
);
  if (DEPTH > (1 << AW) || DEPTH == 0) begin : g_bad_depth
    $error("bax_file_mem: bad depth");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock_i) begin
    if (enable_i) begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule

//--- logic/bax_pkg.sv
package bax_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned NIB_W      = 4;
  localparam logic [7:0]  W_RESET    = 8'h00;
  localparam logic        FLAG_RESET = 1'b0;
  localparam logic        DEST_W     = 1'b0;
  localparam logic        DEST_FILE  = 1'b1;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned EXEC_CYCLES = 1;

  typedef enum logic [1:0] {
    sub_w_from_file_op,
    xor_w_file_op,
    xor_literal_op,
    nibble_swap_op
  } bax_op_t;

  typedef struct packed {
    bax_op_t          op;
    logic [ADDR_W-1:0] addr;
    logic             dest;
    logic [DATA_W-1:0] literal;
  } bax_instr_t;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } bax_flags_t;
endpackage

//--- logic/bax_top.sv
`timescale 1ns/1ps
module bax_top
  import bax_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire logic         enable_i,
  input  wire logic         instr_valid_i,
  input  wire bax_instr_t   instr_i,
  output logic [DATA_W-1:0] w_o,
  output bax_flags_t        flags_o,
  output logic              done_o
);
  logic [DATA_W-1:0] rd_data;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic              valid_q;
  bax_instr_t        instr_q;

  // Operand fetch stage: memory read is registered
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      valid_q <= 1'b0;
      instr_q <= '0;
    end else if (enable_i) begin
      valid_q <= instr_valid_i;
      instr_q <= instr_i;
    end
  end

  bax_file_mem u_mem (
    .clock_i   (clock_i),
    .enable_i  (enable_i),
    .rd_addr_i (instr_i.addr),
    .rd_data_o (rd_data),
    .wr_en_i   (wr_en),
    .wr_addr_i (wr_addr),
    .wr_data_i (wr_data)
  );

  bax_alu u_alu (
    .clock_i        (clock_i),
    .reset_i        (reset_i),
    .enable_i       (enable_i),
    .instr_valid_i  (valid_q),
    .instr_i        (instr_q),
    .file_rd_data_i (rd_data),
    .file_wr_en_o   (wr_en),
    .file_wr_addr_o (wr_addr),
    .file_wr_data_o (wr_data),
    .w_o            (w_o),
    .flags_o        (flags_o),
    .done_o         (done_o)
  );
endmodule

//--- verif/bax_chk_properties.sv
`timescale 1ns/1ps
module bax_chk
  import bax_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              reset_i,
  input wire logic              enable_i,
  input wire logic              instr_valid_i,
  input wire bax_instr_t        instr_i,
  input wire logic [DATA_W-1:0] w_o,
  input wire bax_flags_t        flags_o,
  input wire logic              done_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence took(bax_op_t o);
    enable_i && instr_valid_i && instr_i.op == o ##1 enable_i;
  endsequence
  sequence to_file;
    enable_i && instr_valid_i && instr_i.op != xor_literal_op && instr_i.dest ##1 enable_i;
  endsequence
  done_lat_a: assert property (enable_i && instr_valid_i ##1 enable_i |=> done_o)
    else $error("late done");
  w_hold_a: assert property (!done_o |-> $stable(w_o)) else $error("w moved");
  flag_hold_a: assert property (!done_o |-> $stable(flags_o)) else $error("flags moved");
  lit_xor_a: assert property (took(xor_literal_op) |=>
    w_o == ($past(w_o) ^ $past(instr_i.literal, 2))) else $error("bad xor");
  lit_zero_a: assert property (took(xor_literal_op) |=> flags_o.zero == (w_o == 8'h00))
    else $error("bad zero");
  lit_cdc_a: assert property (took(xor_literal_op) |=>
    {flags_o.carry, flags_o.digit_carry_flag} == $past({flags_o.carry, flags_o.digit_carry_flag}))
    else $error("carry moved");
  file_dest_a: assert property (to_file |=> $stable(w_o)) else $error("w written");
  swap_flag_a: assert property (took(nibble_swap_op) |=> $stable(flags_o))
    else $error("swap flags");
  freeze_a: assert property (!enable_i |=> $stable({w_o, flags_o, done_o}))
    else $error("not frozen");
  cover property (took(xor_literal_op));
  cover property (took(nibble_swap_op));
  cover property (took(sub_w_from_file_op));
endmodule
bind bax_top bax_chk u_chk (.*);

//--- verif/bax_issuer.sv
`timescale 1ns/1ps
module bax_issuer
  import bax_pkg::*;
(
  input  wire logic clock_i,
  output logic      valid_o,
  output bax_instr_t instr_o
);
  initial begin
    valid_o = 1'b0;
    instr_o = '0;
  end
  // Holds valid so two sends run back to back
  task automatic send(input bax_op_t op, input logic [7:0] lit, input logic dest);
    @(negedge clock_i);
    valid_o = 1'b1;
    instr_o = '{op, 7'h05, dest, lit};
  endtask
  task automatic idle();
    @(negedge clock_i);
    valid_o = 1'b0;
  endtask
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bax_pkg::*;
  logic       clock_i, reset_i, enable_i, valid, done;
  logic [7:0] w, ew;
  bax_instr_t instr;
  bax_flags_t fl, ef;
  int         fail_count, checks, cyc;
  bax_op_t    ops [3] = '{nibble_swap_op, xor_w_file_op, sub_w_from_file_op};
  logic [7:0] fm;
  bax_op_t    s_op [11] = '{sub_w_from_file_op, nibble_swap_op, xor_w_file_op, xor_w_file_op,
                            xor_literal_op, sub_w_from_file_op, xor_literal_op,
                            sub_w_from_file_op, sub_w_from_file_op, sub_w_from_file_op,
                            nibble_swap_op};
  logic [7:0] s_k  [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hec, 8'h00, 8'h0f, 8'h00, 8'h00,
                            8'h00, 8'h00};
  logic       s_d  [11] = '{DEST_W, DEST_W, DEST_W, DEST_FILE, DEST_W, DEST_W, DEST_W, DEST_W,
                            DEST_FILE, DEST_W, DEST_W};
  `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
  bax_issuer iss (.clock_i(clock_i), .valid_o(valid), .instr_o(instr));
  bax_top dut (.clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i),
    .instr_valid_i(valid), .instr_i(instr), .w_o(w), .flags_o(fl), .done_o(done));
  initial begin
    clock_i = 0;
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 400) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_done(input int n);
    int k;
    k = 0;
    while (done !== 1'b1 && k < 6) begin
      @(negedge clock_i);
      k++;
    end
    `CHK("latency", n, k)
  endtask
  task automatic expect_lit(input logic [7:0] k);
    ew = ew ^ k;
    ef.zero = (ew == 8'h00);
    `CHK("w", ew, w)
    `CHK("flags", ef, fl)
  endtask
  // Model of one instruction against the file word at address 5
  task automatic step(input bax_op_t op, input logic [7:0] k, input logic d);
    logic [7:0] r;
    r = 8'h00;
    unique case (op)
      sub_w_from_file_op: begin
        r  = fm - ew;
        ef = '{ew <= fm, ew[3:0] <= fm[3:0], r == 8'h00};
      end
      xor_w_file_op: r = fm ^ ew;
      xor_literal_op: r = ew ^ k;
      nibble_swap_op: r = {fm[3:0], fm[7:4]};
    endcase
    if (op == xor_w_file_op || op == xor_literal_op) ef.zero = (r == 8'h00);
    if (op == xor_literal_op || d == DEST_W) ew = r;
    else fm = r;
    iss.send(op, k, d);
    iss.idle();
    wait_done(1);
    `CHK("w", ew, w)
    `CHK("flags", ef, fl)
  endtask
  task automatic lit(input logic [7:0] k, input logic d);
    iss.send(xor_literal_op, k, d);
    iss.idle();
    wait_done(1);
    expect_lit(k);
  endtask
  initial begin
    reset_i = 1; enable_i = 1; fail_count = 0; checks = 0; cyc = 0; ew = W_RESET;
    ef = '{FLAG_RESET, FLAG_RESET, FLAG_RESET};
    repeat (5) @(negedge clock_i);
    dut.u_mem.mem[5] = 8'hc3;
    fm = 8'hc3;
    reset_i = 0;
    `CHK("w_rst", W_RESET, w)
    `CHK("fl_rst", 3'h0, fl)
    lit(8'h5a, DEST_W);
    lit(8'h5a, DEST_FILE);
    lit(8'hff, DEST_W);
    iss.send(xor_literal_op, 8'h81, DEST_W);
    iss.send(xor_literal_op, 8'h18, DEST_W);
    iss.idle();
    expect_lit(8'h81);
    @(negedge clock_i);
    expect_lit(8'h18);
    iss.send(xor_literal_op, 8'h0f, DEST_W);
    iss.idle();
    enable_i = 0;
    repeat (3) @(negedge clock_i);
    enable_i = 1;
    wait_done(1);
    expect_lit(8'h0f);
    foreach (ops[i]) begin
      step(ops[i], 8'h00, DEST_FILE);
      `CHK("w_kept", ew, w)
      if (ops[i] == nibble_swap_op) `CHK("swap_fl", ef, fl)
    end
    foreach (s_op[i]) step(s_op[i], s_k[i], s_d[i]);
    reset_i = 1;
    repeat (2) @(negedge clock_i);
    reset_i = 0;
    `CHK("w_rst2", W_RESET, w)
    `CHK("fl_rst2", 3'h0, fl)
    give_verdict();
  end
endmodule
